// *** verilog/bcfg_regs.sv ***
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Bits 15:10 set each stop and tri-state one of six PCI clock outputs.
// - Prefetch field 00 allows prefetch on read, read line, read multiple.
// - Prefetch field 01 allows prefetch only on read line and multiple.
// - Prefetch field 10 or 11 disables all prefetching.
// - Depth bit 0 gives four 256-byte buffers, 1 gives two 512-byte.
// - Test mode limits delayed transactions 4/4, 1/1, 2/2; 11 reserved.
// - Arbiter holds grant for the time slice, then grants another requester.
// - Time-slice value zero disables the mechanism.
// - Count bits 7:3 in 8-clock units; slice equals value in clocks.
module bcfg_regs (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        clk_en_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic        pci_clk_src_i,
    output logic      [5:0]  pci_clock_out_o,
    output logic      [5:0]  pci_clock_oe_o,
    input  wire logic [3:0]  read_cmd_i,
    output logic             prefetch_ok_o,
    output logic             delayed_txn_depth_o,
    output logic      [2:0]  dt_buf_count_o,
    output logic      [9:0]  dt_buf_bytes_o,
    input  wire logic        test_mode_i,
    output logic      [2:0]  dt_max_active_o,
    output logic      [2:0]  dt_max_pending_o,
    input  wire logic        txn_start_i,
    input  wire logic        other_req_i,
    output logic             slice_hold_o,
    output logic             slice_expired_o
);
    import bcfg_pkg::*;

    typedef struct packed {
        logic [15:0] conf;
        logic [7:0]  multi_transaction_timer;
        logic [15:0] rdata;
        logic [1:0]  clk_sync0;
        logic [1:0]  clk_sync1;
        logic [5:0]  clk_out;
        logic [5:0]  clk_oe;
        logic        pf_ok;
        logic        depth;
        logic [2:0]  buf_count;
        logic [9:0]  buf_bytes;
        logic [2:0]  max_act;
        logic [2:0]  max_pend;
        bcfg_slice_e slice;
        logic [7:0]  cnt;
        logic        hold;
        logic        expired;
    } bcfg_state_s;

    bcfg_state_s st_r;
    bcfg_state_s st_nxt;

    // Field views of the stored registers
    logic [1:0]  pf_field;
    logic [1:0]  maxdt_field;
    logic        depth_bit;
    logic [5:0]  clk_dis;
    logic [7:0]  slice_len;

    // Register bus decode
    logic        wr_conf;
    logic        wr_mtt;
    logic        rd_conf;
    logic        rd_mtt;

    // Read command decode
    logic        cmd_mrd;
    logic        cmd_mrl;
    logic        cmd_mrm;

    // Slice timer helpers
    logic        slice_on;
    logic        cnt_last;

    // Source clock after the synchroniser chain
    logic        src_sync;

    // Slices of the configuration and timer registers
    assign pf_field    = st_r.conf[BCFG_PF_LSB +: 2];
    assign maxdt_field = st_r.conf[BCFG_MAXDT_LSB +: 2];
    assign depth_bit   = st_r.conf[BCFG_DEPTH_BIT];
    assign clk_dis     = st_r.conf[BCFG_CLKDIS_LSB +: BCFG_NCLK];
    assign slice_len   = st_r.multi_transaction_timer & BCFG_MTT_WMASK;

    // Strobe and address match for each register
    assign wr_conf = wr_i && (addr_i == BCFG_CONF_OFF);
    assign wr_mtt  = wr_i && (addr_i == BCFG_MTT_OFF);
    assign rd_conf = rd_i && (addr_i == BCFG_CONF_OFF);
    assign rd_mtt  = rd_i && (addr_i == BCFG_MTT_OFF);

    // Command match against the standard read encodings
    assign cmd_mrd = (read_cmd_i == BCFG_CMD_MRD);
    assign cmd_mrl = (read_cmd_i == BCFG_CMD_MRL);
    assign cmd_mrm = (read_cmd_i == BCFG_CMD_MRM);

    // A zero count field switches the slice mechanism off
    assign slice_on = (slice_len != 8'h00);
    assign cnt_last = (st_r.cnt <= 8'h01);

    // Only the last stage of the chain feeds the clock gates
    assign src_sync = st_r.clk_sync1[1];

    // Next-state logic for registers, derived controls and slice timer
    always_comb begin
        // Every field holds unless a branch below updates it
        st_nxt = st_r;

        // Read data is zero outside the cycle after a read strobe
        st_nxt.rdata = 16'h0000;

        // Configuration write; reserved bits masked to zero
        if (wr_conf) begin
            st_nxt.conf = wdata_i & BCFG_CONF_WMASK;
        end

        // Timer write; upper data byte and reserved low bits dropped
        if (wr_mtt) begin
            st_nxt.multi_transaction_timer = wdata_i[7:0] & BCFG_MTT_WMASK;
        end

        // Read data, valid the cycle after the strobe; unmapped reads zero
        if (rd_conf) begin
            st_nxt.rdata = st_r.conf;
        end else if (rd_mtt) begin
            st_nxt.rdata = {8'h00, st_r.multi_transaction_timer};
        end else begin
            st_nxt.rdata = 16'h0000;
        end

        // Source clock passes four flops before anything reads it
        st_nxt.clk_sync0 = {st_r.clk_sync0[0], pci_clk_src_i};
        st_nxt.clk_sync1 = {st_r.clk_sync1[0], st_r.clk_sync0[1]};

        // Prefetch permission for the command now on the bus
        case (pf_field)
            BCFG_PF_ALL: begin
                // Plain read, read line and read multiple
                st_nxt.pf_ok = cmd_mrd || cmd_mrl || cmd_mrm;
            end
            BCFG_PF_LINE_MULT: begin
                // Plain read is excluded here
                st_nxt.pf_ok = cmd_mrl || cmd_mrm;
            end
            default: begin
                // Both remaining codes turn prefetching off
                st_nxt.pf_ok = 1'b0;
            end
        endcase

        // Buffer arrangement follows the depth bit
        st_nxt.depth = depth_bit;
        if (depth_bit) begin
            // Two deep buffers for small systems
            st_nxt.buf_count = BCFG_CNT_2;
            st_nxt.buf_bytes = BCFG_BUF_LARGE;
        end else begin
            // Four shallow buffers by default
            st_nxt.buf_count = BCFG_CNT_4;
            st_nxt.buf_bytes = BCFG_BUF_SMALL;
        end

        // Delayed transaction limits, applied only in test mode
        if (!test_mode_i) begin
            // Normal operation always allows the full set
            st_nxt.max_act  = BCFG_CNT_4;
            st_nxt.max_pend = BCFG_CNT_4;
        end else begin
            case (maxdt_field)
                BCFG_DT_FOUR: begin
                    st_nxt.max_act = BCFG_CNT_4;
                end
                BCFG_DT_ONE: begin
                    st_nxt.max_act = BCFG_CNT_1;
                end
                BCFG_DT_TWO: begin
                    st_nxt.max_act = BCFG_CNT_2;
                end
                default: begin
                    // Reserved code allows nothing rather than guess
                    st_nxt.max_act = BCFG_CNT_0;
                end
            endcase
            // Pending limit always equals the active limit
            st_nxt.max_pend = st_nxt.max_act;
        end

        // Multi-transaction time slice
        case (st_r.slice)
            BCFG_IDLE: begin
                // No grant is held while idle
                st_nxt.expired = 1'b0;
                st_nxt.hold    = 1'b0;
                // A new series opens a slice only when the timer is on
                if (txn_start_i && slice_on) begin
                    st_nxt.slice = BCFG_HOLD;
                    st_nxt.cnt   = slice_len;
                    st_nxt.hold  = 1'b1;
                end
            end
            BCFG_HOLD: begin
                if (!slice_on) begin
                    // Clearing the timer aborts the slice at once
                    st_nxt.slice = BCFG_IDLE;
                    st_nxt.hold  = 1'b0;
                end else if (cnt_last) begin
                    // Slice used up; release the grant
                    st_nxt.hold = 1'b0;
                    st_nxt.cnt  = 8'h00;
                    if (other_req_i) begin
                        // Hand the bus to the waiting agent
                        st_nxt.expired = 1'b1;
                        st_nxt.slice   = BCFG_EXPIRED;
                    end else begin
                        // Nobody waits, so just go back to idle
                        st_nxt.slice = BCFG_IDLE;
                    end
                end else begin
                    // One more clock of the slice gone
                    st_nxt.cnt = st_r.cnt - 8'h01;
                end
            end
            BCFG_EXPIRED: begin
                // Expiry is a single-cycle pulse
                st_nxt.expired = 1'b0;
                st_nxt.slice   = BCFG_IDLE;
            end
            default: begin
                // Unused encoding recovers to idle
                st_nxt.slice = BCFG_IDLE;
            end
        endcase

        // Clock outputs gated and released by their disable bits
        st_nxt.clk_out = '0;
        st_nxt.clk_oe  = '0;
        for (int i = 0; i < BCFG_NCLK; i++) begin
            st_nxt.clk_out[i] = src_sync & ~clk_dis[i];
            st_nxt.clk_oe[i]  = ~clk_dis[i];
        end
    end

    // State register with clock enable and synchronous reset
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st_r <= '0;
            st_r.conf <= BCFG_CONF_RST;
            st_r.multi_transaction_timer <= BCFG_MTT_RST;
            st_r.slice <= BCFG_IDLE;
            st_r.clk_oe <= 6'h3F;
            st_r.buf_count <= BCFG_CNT_4;
            st_r.buf_bytes <= BCFG_BUF_SMALL;
            st_r.max_act <= BCFG_CNT_4;
            st_r.max_pend <= BCFG_CNT_4;
        end else if (clk_en_i) begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o             = st_r.rdata;
    assign pci_clock_out_o     = st_r.clk_out;
    assign pci_clock_oe_o      = st_r.clk_oe;
    assign prefetch_ok_o       = st_r.pf_ok;
    assign delayed_txn_depth_o = st_r.depth;
    assign dt_buf_count_o      = st_r.buf_count;
    assign dt_buf_bytes_o      = st_r.buf_bytes;
    assign dt_max_active_o     = st_r.max_act;
    assign dt_max_pending_o    = st_r.max_pend;
    assign slice_hold_o        = st_r.hold;
    assign slice_expired_o     = st_r.expired;
endmodule
`default_nettype wire

// *** verilog/bcfg_pkg.sv ***
`default_nettype none
package bcfg_pkg;
    // Register byte offsets
    localparam logic [7:0]  BCFG_CONF_OFF      = 8'h50;
    localparam logic [7:0]  BCFG_MTT_OFF       = 8'h70;
    // Reset values
    localparam logic [15:0] BCFG_CONF_RST      = 16'h0000;
    localparam logic [7:0]  BCFG_MTT_RST       = 8'h00;
    // Writable bit masks, reserved bits stay zero
    localparam logic [15:0] BCFG_CONF_WMASK    = 16'hFC1F;
    localparam logic [7:0]  BCFG_MTT_WMASK     = 8'hF8;
    // Field positions
    localparam int          BCFG_CLKDIS_LSB    = 10;
    localparam int          BCFG_NCLK          = 6;
    localparam int          BCFG_PF_LSB        = 3;
    localparam int          BCFG_DEPTH_BIT     = 2;
    localparam int          BCFG_MAXDT_LSB     = 0;
    // Prefetch policy encodings
    localparam logic [1:0]  BCFG_PF_ALL        = 2'h0;
    localparam logic [1:0]  BCFG_PF_LINE_MULT  = 2'h1;
    // Delayed transaction limit encodings
    localparam logic [1:0]  BCFG_DT_FOUR       = 2'h0;
    localparam logic [1:0]  BCFG_DT_ONE        = 2'h1;
    localparam logic [1:0]  BCFG_DT_TWO        = 2'h2;
    localparam logic [2:0]  BCFG_CNT_4         = 3'h4;
    localparam logic [2:0]  BCFG_CNT_2         = 3'h2;
    localparam logic [2:0]  BCFG_CNT_1         = 3'h1;
    localparam logic [2:0]  BCFG_CNT_0         = 3'h0;
    // Buffer sizes in bytes
    localparam logic [9:0]  BCFG_BUF_SMALL     = 10'h100;
    localparam logic [9:0]  BCFG_BUF_LARGE     = 10'h200;
    // PCI read command codes
    localparam logic [3:0]  BCFG_CMD_MRD       = 4'h6;
    localparam logic [3:0]  BCFG_CMD_MRL       = 4'hE;
    localparam logic [3:0]  BCFG_CMD_MRM       = 4'hC;
    // Arbiter slice states
    typedef enum logic [1:0] {BCFG_IDLE, BCFG_HOLD, BCFG_EXPIRED} bcfg_slice_e;
endpackage
`default_nettype wire

// *** verif/bcfg_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module bcfg_chk
    import bcfg_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        clk_en_i,
    input wire logic [7:0]  addr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic [5:0]  pci_clock_out_o,
    input wire logic [5:0]  pci_clock_oe_o,
    input wire logic        delayed_txn_depth_o,
    input wire logic [2:0]  dt_buf_count_o,
    input wire logic [9:0]  dt_buf_bytes_o,
    input wire logic [2:0]  dt_max_active_o,
    input wire logic [2:0]  dt_max_pending_o,
    input wire logic        txn_start_i,
    input wire logic        slice_hold_o,
    input wire logic        slice_expired_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Read request to one register
    sequence s_rd(a);
        clk_en_i && rd_i && addr_i == a;
    endsequence
    property p_clk_off; (pci_clock_out_o & ~pci_clock_oe_o) == 6'h00; endproperty
    a_clk_off: assert property (p_clk_off) else $error("clock toggles while tri-stated");
    property p_rd_idle; clk_en_i && !rd_i |=> rdata_o == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_conf_rsv; s_rd(BCFG_CONF_OFF) |=> rdata_o[9:5] == 5'h00; endproperty
    a_conf_rsv: assert property (p_conf_rsv) else $error("config reserved bits set");
    property p_mtt_rsv; s_rd(BCFG_MTT_OFF) |=> rdata_o[15:8] == 8'h00 && rdata_o[2:0] == 3'h0;
    endproperty
    a_mtt_rsv: assert property (p_mtt_rsv) else $error("timer reserved bits set");
    property p_depth;
        dt_buf_count_o == (delayed_txn_depth_o ? BCFG_CNT_2 : BCFG_CNT_4) &&
        dt_buf_bytes_o == (delayed_txn_depth_o ? BCFG_BUF_LARGE : BCFG_BUF_SMALL);
    endproperty
    a_depth: assert property (p_depth) else $error("buffer layout wrong");
    property p_dt_pair; dt_max_active_o == dt_max_pending_o; endproperty
    a_dt_pair: assert property (p_dt_pair) else $error("active and pending differ");
    property p_exp_pulse; slice_expired_o |=> !slice_expired_o; endproperty
    a_exp_pulse: assert property (p_exp_pulse) else $error("expiry longer than one cycle");
    property p_exp_end; slice_expired_o |-> $fell(slice_hold_o); endproperty
    a_exp_end: assert property (p_exp_end) else $error("expiry without end of hold");
    property p_hold_cause; $rose(slice_hold_o) |-> $past(txn_start_i); endproperty
    a_hold_cause: assert property (p_hold_cause) else $error("hold without start");
endmodule
bind bcfg_regs bcfg_chk bcfg_chk_inst (.clk_i, .reset_n_i, .clk_en_i, .addr_i, .rd_i, .rdata_o,
    .pci_clock_out_o, .pci_clock_oe_o, .delayed_txn_depth_o, .dt_buf_count_o, .dt_buf_bytes_o,
    .dt_max_active_o, .dt_max_pending_o, .txn_start_i, .slice_hold_o, .slice_expired_o);
`default_nettype wire

// *** verif/bcfg_pci_agent.sv ***
`timescale 1ns/1ns
`default_nettype none
module bcfg_pci_agent (
    input  wire logic clk_i,
    input  wire logic burst_i,
    input  wire logic rival_i,
    output var logic  txn_start_o = 1'b0,
    output var logic  other_req_o = 1'b0,
    output var logic  clk_src_o = 1'b0
);
    // Initiators request after a clock edge; source clock flips every cycle
    always @(posedge clk_i) begin
        clk_src_o   <= ~clk_src_o;
        txn_start_o <= burst_i;
        other_req_o <= rival_i;
    end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import bcfg_pkg::*;
    logic clk_i = 0, reset_n_i = 0, clk_en_i = 1, wr_i = 0, rd_i = 0, test_mode_i = 0;
    logic burst = 0, rival = 0;
    logic [7:0] addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000, rdata_o;
    logic [3:0] read_cmd_i = 4'h0;
    logic [5:0] pci_clock_out_o, pci_clock_oe_o, seen;
    logic [2:0] dt_buf_count_o, dt_max_active_o, dt_max_pending_o, cnt_exp[4];
    logic [9:0] dt_buf_bytes_o;
    logic [3:0] cmds[3];
    logic pci_clk_src_i, prefetch_ok_o, delayed_txn_depth_o, txn_start_i, other_req_i;
    logic slice_hold_o, slice_expired_o, expired;
    int n_errors = 0, checks_done = 0, held;
    bcfg_regs bcfg_regs_inst (.clk_i, .reset_n_i, .clk_en_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .pci_clk_src_i, .pci_clock_out_o, .pci_clock_oe_o, .read_cmd_i, .prefetch_ok_o,
        .delayed_txn_depth_o, .dt_buf_count_o, .dt_buf_bytes_o, .test_mode_i, .dt_max_active_o,
        .dt_max_pending_o, .txn_start_i, .other_req_i, .slice_hold_o, .slice_expired_o);
    bcfg_pci_agent bcfg_pci_agent_inst (.clk_i, .burst_i(burst), .rival_i(rival),
        .txn_start_o(txn_start_i), .other_req_o(other_req_i), .clk_src_o(pci_clk_src_i));
    // Clock, 40 ns period
    initial forever #20 clk_i = ~clk_i;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        repeat (2) @(negedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk(rdata_o, exp);
    endtask
    // One-cycle burst start; counts held cycles and expiry
    task automatic slice(input logic other);
        @(posedge clk_i);
        burst <= 1'b1;
        rival <= other;
        @(posedge clk_i);
        burst <= 1'b0;
        held = 0;
        expired = 1'b0;
        for (int i = 0; i < 60; i++) begin
            @(negedge clk_i);
            held += slice_hold_o;
            expired |= slice_expired_o;
        end
        rival <= 1'b0;
    endtask
    task automatic final_report;
        if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence
    initial begin
        cmds = '{BCFG_CMD_MRD, BCFG_CMD_MRL, BCFG_CMD_MRM};
        cnt_exp = '{3'h4, 3'h1, 3'h2, 3'h0};
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(BCFG_CONF_OFF, BCFG_CONF_RST);
        rd(BCFG_MTT_OFF, {8'h00, BCFG_MTT_RST});
        seen = 6'h00;
        repeat (8) @(negedge clk_i) seen |= pci_clock_out_o;
        chk(seen, 6'h3F);
        wr(BCFG_CONF_OFF, 16'hFFFF);
        chk(pci_clock_oe_o, 6'h00);
        rd(BCFG_CONF_OFF, BCFG_CONF_WMASK);
        wr(8'h60, 16'hFFFF);
        rd(8'h60, 16'h0000);
        for (int p = 0; p < 4; p++) begin
            wr(BCFG_CONF_OFF, 16'(p << 3));
            for (int c = 0; c < 3; c++) begin
                @(posedge clk_i) read_cmd_i <= cmds[c];
                repeat (2) @(negedge clk_i);
                chk(prefetch_ok_o, p == 0 || (p == 1 && c != 0));
            end
        end
        // Two masters in this system, so the deeper buffers are allowed
        wr(BCFG_CONF_OFF, 16'h0004);
        chk(delayed_txn_depth_o, 1'b1);
        chk({dt_buf_count_o, dt_buf_bytes_o}, {BCFG_CNT_2, BCFG_BUF_LARGE});
        @(posedge clk_i) test_mode_i <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            wr(BCFG_CONF_OFF, 16'(k));
            chk({dt_max_active_o, dt_max_pending_o}, {cnt_exp[k], cnt_exp[k]});
        end
        // Leaving test mode restores the full limits
        @(posedge clk_i) test_mode_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        chk({dt_max_active_o, dt_max_pending_o}, {BCFG_CNT_4, BCFG_CNT_4});
        wr(BCFG_MTT_OFF, 16'hFFFF);
        rd(BCFG_MTT_OFF, 16'h00F8);
        wr(BCFG_MTT_OFF, 16'h0018);
        slice(1'b1);
        chk(16'(held), 16'd24);
        chk(expired, 1'b1);
        wr(BCFG_MTT_OFF, 16'h0000);
        slice(1'b1);
        chk(16'(held), 16'd0);
        // A write while the clock enable is low must not land
        @(posedge clk_i) clk_en_i <= 1'b0;
        wr(BCFG_CONF_OFF, 16'h0010);
        @(posedge clk_i) clk_en_i <= 1'b1;
        rd(BCFG_CONF_OFF, 16'h0003);
        // Reset in mid-run returns registers and enables to defaults
        @(posedge clk_i) reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rd(BCFG_CONF_OFF, BCFG_CONF_RST);
        chk(pci_clock_oe_o, 6'h3F);
        final_report();
    end
endmodule
`default_nettype wire
